// ==== bench/fsm_assertions.sv ====
// fsm_assertions: port checks of fsm_regs
// assumes one clk domain and async low reset_n
`timescale 1ns/10ps
module fsm_assertions
	import fsm_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire fsm_cond_s cond_raw,
	input wire fsm_req_s req,
	input wire logic [7:0] rdata_q,
	input wire logic rvalid_q,
	input wire logic irq_n_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire [7:0] live = {cond_raw[5:3], 2'h0, cond_raw[2:0]};
	sequence calm; $stable(cond_raw)[*8]; endsequence
	sequence ack_rd; req.rd && req.addr == FSM_OFS_ACK; endsequence
	AST_RVALID: assert property (req.rd |=> rvalid_q)
		else $error("read got no answer");
	AST_UNMAPPED: assert property (req.rd && req.addr > 8'h03 |=> !rdata_q)
		else $error("unmapped read not zero");
	AST_SENSE: assert property (calm ##0 req.rd &&
		req.addr == FSM_OFS_SENSE |=> rdata_q == $past(live))
		else $error("sense value wrong");
	AST_ACKCLR: assert property (calm ##0 ack_rd ##2 ack_rd |=> !rdata_q)
		else $error("ack not cleared");
	AST_IRQCLR: assert property (calm ##0 ack_rd |-> ##2 irq_n_q)
		else $error("irq held after clear");
	AST_MASKALL: assert property (req.wr && req.addr == FSM_OFS_MASK &&
		req.wdata == 8'hFF |=> ##1 irq_n_q)
		else $error("irq with all masked");
	cover property (req.wr);
	cover property ($fell(irq_n_q));
	cover property (rvalid_q);
endmodule : fsm_assertions

// ==== bench/fsm_host.sv ====
// fsm_host: control bus host, one request per call
// assumes strobes are taken at the rising edge
`timescale 1ns/10ps
module fsm_host
	import fsm_pkg::*;
(
	input wire logic clk,
	output fsm_req_s req
);
	initial req = '0;
	task automatic acc(input logic r, w, input logic [7:0] a, d);
		@(negedge clk);
		req <= '{r, w, a, d};
	endtask : acc
endmodule : fsm_host

// ==== bench/tb_top.sv ====
// tb_top: random conditions and masks against fsm_regs
// assumes fsm_pkg, fsm_regs, fsm_host, fsm_assertions
`timescale 1ns/10ps
module tb_top
	import fsm_pkg::*;
;
	logic clk = 0, reset_n = 0, rvalid_q, irq_n_q;
	fsm_cond_s cond_raw = '0, prev = '0;
	fsm_req_s req;
	logic [7:0] rdata_q, m;
	int n_fail = 0, samples_checked = 0, cyc = 0;
	always #5 clk = ~clk;
	fsm_host host (.clk(clk), .req(req));
	localparam logic [7:0] ID_EXP = 8'h5A; // arbitrary value
	fsm_regs #(.PRODUCT_ID(ID_EXP)) dut (.clk(clk), .reset_n(reset_n),
		.cond_raw(cond_raw),
		.req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .irq_n_q(irq_n_q));
	function automatic logic [7:0] sense(input fsm_cond_s c);
		return {c[5:3], 2'h0, c[2:0]};
	endfunction : sense
	task automatic check(input logic [7:0] got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %0t %h %h", $time, got, exp);
		end
	endtask : check
	task automatic rd(input logic [7:0] a, exp);
		host.acc(1, 0, a, 8'h00);
		host.acc(0, 0, 8'h00, 8'h00);
		check(rvalid_q, 8'h01);
		check(rdata_q, exp);
	endtask : rd
	task automatic final_report;
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			final_report();
		end
	end
	initial
	begin
		void'($urandom(32'hEB7B474B));
		repeat (20) @(negedge clk);
		reset_n = 1;
		rd(FSM_OFS_MASK, FSM_MASK_RESET);
		rd(FSM_OFS_PRODUCT, ID_EXP);
		rd(8'h07, 8'h00);
		repeat (30)
		begin
			cond_raw = 6'($urandom);
			m = 8'($urandom);
			repeat (8) @(negedge clk);
			rd(FSM_OFS_SENSE, sense(cond_raw));
			host.acc(0, 1, FSM_OFS_MASK, m);
			rd(FSM_OFS_MASK, m | FSM_SPARE_BITS);
			check(irq_n_q, !(sense(cond_raw ^ prev) & ~m));
			rd(FSM_OFS_ACK, sense(cond_raw ^ prev));
			rd(FSM_OFS_ACK, 8'h00);
			check(irq_n_q, 8'h01);
			host.acc(0, 1, FSM_OFS_MASK, 8'hFF);
			host.acc(0, 0, 8'h00, 8'h00);
			prev = cond_raw;
		end
		final_report();
	end
endmodule : tb_top
bind fsm_regs fsm_assertions chk (.clk(clk), .reset_n(reset_n),
	.cond_raw(cond_raw), .req(req), .rdata_q(rdata_q),
	.rvalid_q(rvalid_q), .irq_n_q(irq_n_q));

// ==== design/fsm_pkg.sv ====
// fsm_pkg: register map, field layout and reset values of the fault
// sense and mask block; assumes 8-bit registers at byte offsets.
package fsm_pkg;
	localparam logic [7:0] FSM_OFS_ACK = 8'h00;
	localparam logic [7:0] FSM_OFS_SENSE = 8'h01;
	localparam logic [7:0] FSM_OFS_MASK = 8'h02;
	localparam logic [7:0] FSM_OFS_PRODUCT = 8'h03;
	localparam logic [7:0] FSM_ACK_RESET = 8'h00;
	localparam logic [7:0] FSM_SENSE_RESET = 8'h00;
	localparam logic [7:0] FSM_MASK_RESET = 8'hFF;
	localparam logic [7:0] FSM_SPARE_BITS = 8'h18;
	localparam logic [7:0] FSM_ZERO = 8'h00;
	localparam int FSM_BIT_PG = 0;
	localparam int FSM_BIT_OC = 1;
	localparam int FSM_BIT_UV = 2;
	localparam int FSM_BIT_TPRE = 5;
	localparam int FSM_BIT_TWARN = 6;
	localparam int FSM_BIT_TSD = 7;
	localparam int FSM_SYNC_STAGES = 3;

	// raw regulator conditions from the analog comparators
	typedef struct packed {
		logic thermal_shutdown;
		logic thermal_warning;
		logic thermal_prewarn;
		logic undervoltage;
		logic overcurrent;
		logic power_good;
	} fsm_cond_s;

	// one register access from the control interface
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fsm_req_s;
endpackage : fsm_pkg

// ==== design/fsm_regs.sv ====
// fsm_regs: live sense, acknowledge latch, mask and product id registers
// with the interrupt output; assumes the control interface delivers
// single-cycle read and write strobes on clk.
// Function
// - overcurrent sense bit high over current limit, low below it.
// - thermal warning sense bit high over warning threshold, low below.
// - overcurrent mask bit 0 enables its interrupt source, 1 suppresses it.
// - thermal shutdown mask bit 0 enables its source, 1 masks it.
// - power good, undervoltage, prewarn, warning masks: 0 enables, 1 masks.
// - ack bit latches on either sense edge; a read clears it.
`timescale 1ns/10ps
module fsm_regs
	import fsm_pkg::*;
#(
	parameter logic [7:0] PRODUCT_ID = 8'h5A // arbitrary value
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire fsm_cond_s cond_raw,
	input wire fsm_req_s req,
	output logic [7:0] rdata_q,
	output logic rvalid_q,
	output logic irq_n_q
);
	// synchronised condition levels
	logic pg_sync;
	logic oc_sync;
	logic uv_sync;
	logic tpre_sync;
	logic twarn_sync;
	logic tsd_sync;

	// register state
	logic [7:0] sense_q;
	logic [7:0] sense_d;
	logic [7:0] ack_q;
	logic [7:0] mask_q;

	// event detect and access decode
	logic [7:0] edge_hit;
	logic [7:0] irq_src;
	logic ack_read;
	logic sense_read;
	logic mask_read;
	logic product_read;
	logic mask_write;

	// one synchroniser per regulator condition
	// a level counts once stages two and three agree
	fsm_sync u_sync_pg (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(cond_raw.power_good),
		.sync_out(pg_sync)
	);

	fsm_sync u_sync_oc (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(cond_raw.overcurrent),
		.sync_out(oc_sync)
	);

	fsm_sync u_sync_uv (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(cond_raw.undervoltage),
		.sync_out(uv_sync)
	);

	fsm_sync u_sync_tpre (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(cond_raw.thermal_prewarn),
		.sync_out(tpre_sync)
	);

	fsm_sync u_sync_twarn (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(cond_raw.thermal_warning),
		.sync_out(twarn_sync)
	);

	fsm_sync u_sync_tsd (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(cond_raw.thermal_shutdown),
		.sync_out(tsd_sync)
	);

	// sense image, spare bits read zero
	always_comb
	begin
		sense_d = FSM_ZERO;
		sense_d[FSM_BIT_PG] = pg_sync;
		sense_d[FSM_BIT_OC] = oc_sync;
		sense_d[FSM_BIT_UV] = uv_sync;
		sense_d[FSM_BIT_TPRE] = tpre_sync;
		sense_d[FSM_BIT_TWARN] = twarn_sync;
		sense_d[FSM_BIT_TSD] = tsd_sync;
	end

	// access decode, one read strobe per register plus the mask write strobe
	assign ack_read = req.rd && (req.addr == FSM_OFS_ACK);
	assign sense_read = req.rd && (req.addr == FSM_OFS_SENSE);
	assign mask_read = req.rd && (req.addr == FSM_OFS_MASK);
	assign product_read = req.rd && (req.addr == FSM_OFS_PRODUCT);
	assign mask_write = req.wr && (req.addr == FSM_OFS_MASK);

	// edge against the registered sense, so ack sets with sense
	assign edge_hit = sense_d ^ sense_q;
	assign irq_src = ack_q & ~mask_q;

	// live sense register
	// sense follows the synchronised level, one clock behind
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sense_q <= FSM_SENSE_RESET;
		end
		else
		begin
			sense_q <= sense_d;
		end
	end

	// acknowledge latch
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ack_q <= FSM_ACK_RESET;
		end
		else if (ack_read)
		begin
			// a new edge wins over the read clear, no event is lost
			ack_q <= edge_hit;
		end
		else
		begin
			ack_q <= ack_q | edge_hit;
		end
	end

	// mask register, spare bits hold at one
	// writes to other offsets change nothing
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mask_q <= FSM_MASK_RESET;
		end
		else if (mask_write)
		begin
			mask_q <= req.wdata | FSM_SPARE_BITS;
		end
	end

	// interrupt output, active low
	// masked sources keep their ack bit but stay quiet
	// registered so the pin never glitches on a decode change
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_n_q <= 1'b1;
		end
		else
		begin
			irq_n_q <= ~|irq_src;
		end
	end

	// read answer strobe, one cycle after the read edge
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= req.rd;
		end
	end

	// read data, holds until the next read
	// unmapped addresses read zero
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdata_q <= FSM_ZERO;
		end
		else if (ack_read)
		begin
			// ack reads its value from before the clear
			rdata_q <= ack_q;
		end
		else if (sense_read)
		begin
			rdata_q <= sense_q;
		end
		else if (mask_read)
		begin
			rdata_q <= mask_q;
		end
		else if (product_read)
		begin
			rdata_q <= PRODUCT_ID;
		end
		else if (req.rd)
		begin
			rdata_q <= FSM_ZERO;
		end
	end
endmodule : fsm_regs

// ==== design/fsm_sync.sv ====
// fsm_sync: three-stage synchroniser for one asynchronous level;
// assumes the input comes from outside the clk domain.
`timescale 1ns/10ps
module fsm_sync
	import fsm_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic async_in,
	output logic sync_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// change accepted once stages two and three agree
			if (s2_q == s3_q)
				sync_out <= s3_q;
		end
	end
endmodule : fsm_sync
